/* rtl/gpio_port_block.sv */
/*
  one eight-bit general-purpose port: direction, address-masked data,
  edge/level interrupts, alternate-function hand-over with commit
  protection, pad configuration outputs and identification registers.
  assumes a single-cycle register port on mclk_in, pads sampled
  asynchronously and peripheral signals in the mclk_in domain.
*/
// Local design decisions: the address map and the strobed register port.
// Operation
// - ordinary pins reset undriven, all selects cleared except 2 mA drive, which resets set
// - debug pins reset alternate, enabled, pulled up
// - any reset restores both default sets
// - direction 0: pin value captures pad
// - direction 1: pin value drives pad
// - data decodes 256 words, address mask
// - data write changes only masked-in bits
// - data read returns zero for masked bits
// - enabled conditions merge onto one interrupt
// - edge interrupts latch until software clears
// - rising, falling, both edges, or levels
// - mask bit forwards pin condition
// - raw status shows conditions regardless mask
// - masked status shows forwarded conditions only
// - clear write one clears, zero ignored
// - alternate bit hands pad to peripheral
// - protected alternate bits need unlock and permit
// - drive, slew, open drain, pulls, digital enable
// - eight peripheral and four cell identifiers
// - unconnected bits ignore writes
// - debug pin permit bits reset to zero
`default_nettype none
module gpio_port_block
  import gpio_port_pkg::*;
#(
  parameter logic [7:0] debug_pins   = gpio_port_pkg::RST_DEBUG_PINS,
  parameter logic [7:0] present_pins = gpio_port_pkg::RST_PRESENT
) (
  input  wire logic                              mclk_in,        // clock
  input  wire logic                              rstn_in,        // reset
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  addr_in,        // address
  input  wire logic [gpio_port_pkg::DATA_W-1:0]  wdata_in,       // wr data
  input  wire logic                              wr_in,          // wr strobe
  input  wire logic                              rd_in,          // rd strobe
  output logic      [gpio_port_pkg::DATA_W-1:0]  rdata_out,      // rd data
  input  wire logic [7:0]                        pad_in,         // pad level
  output logic      [7:0]                        pad_out,        // pad value
  output logic      [7:0]                        pad_oe_out,     // pad enable
  input  wire logic [7:0]                        alt_out_in,     // periph out
  input  wire logic [7:0]                        alt_oe_in,      // periph oe
  output logic      [7:0]                        alt_in_out,     // to periph
  output logic      [7:0]                        drive_low_out,  // 2 mA
  output logic      [7:0]                        drive_mid_out,  // 4 mA
  output logic      [7:0]                        drive_high_out, // 8 mA
  output logic      [7:0]                        slew_out,       // slew ctl
  output logic      [7:0]                        pull_up_out,    // pull-up
  output logic      [7:0]                        pull_down_out,  // pull-down
  output logic      [7:0]                        dig_en_out,     // input en
  output logic                                   irq_out         // interrupt
);
  import gpio_port_pkg::*;

  // masked bit update shared by all partial writes
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] sel);
    merge = (old_v & ~sel) | (new_v & sel);
  endfunction

  logic [7:0]  pad_meta;
  logic [7:0]  pad_sync;
  logic [7:0]  pad_prev;
  logic [7:0]  pin_value_reg;
  logic [7:0]  pin_direction_reg;
  logic [7:0]  irq_sense_select;
  logic [7:0]  irq_both_edges_select;
  logic [7:0]  irq_event_polarity;
  logic [7:0]  irq_mask_reg;
  logic [7:0]  edge_latch;
  logic [7:0]  alt_function_select;
  logic [7:0]  drive_low_select;
  logic [7:0]  drive_mid_select;
  logic [7:0]  drive_high_select;
  logic [7:0]  open_drain_select;
  logic [7:0]  pull_up_select;
  logic [7:0]  pull_down_select;
  logic [7:0]  slew_select;
  logic [7:0]  digital_input_enable;
  logic [7:0]  commit_permit_reg;
  logic        commit_lock_reg;
  logic [7:0]  pin_in;
  logic [7:0]  raw_irq_status;
  logic [7:0]  masked_irq_status;
  logic [7:0]  level_hit;
  logic [7:0]  edge_hit;
  logic [7:0]  clear_bits;
  logic [7:0]  data_mask;
  logic        data_hit;
  logic [7:0]  wbyte;
  logic [7:0]  alt_writable;
  logic [7:0]  next_pad_out;
  logic [7:0]  next_pad_oe;
  logic [31:0] next_rdata;
  logic [11:0] id_off;

  // two-stage synchroniser; only pad_sync is read by logic
  // pad_prev feeds edge detection and never reads the first stage
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pad_meta <= RST_ZERO;
      pad_sync <= RST_ZERO;
      pad_prev <= RST_ZERO;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
      pad_prev <= pad_sync;
    end
  end

  // digital enable gates the synchronised level
  assign pin_in = pad_sync & digital_input_enable;

  // bus decode
  // only lanes [7:0] carry port bits; the lock word is wider
  // bits 11:10 zero select the 256-word masked data window
  assign wbyte     = wdata_in[7:0] & present_pins;
  assign data_hit  = (addr_in[11:10] == 2'b00);
  assign data_mask = addr_in[DATA_MASK_MSB:DATA_MASK_LSB];

  // byte offset from the first identifier word
  assign id_off = addr_in - OFS_PERIPH_ID0;

  // data register: only masked-in, connected bits change
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pin_value_reg <= RST_ZERO;
    end else if (wr_in && data_hit) begin
      pin_value_reg <= merge(pin_value_reg, wbyte,
                             data_mask & present_pins);
    end
  end

  // direction and interrupt configuration
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pin_direction_reg     <= RST_ZERO;
      irq_sense_select      <= RST_ZERO;
      irq_both_edges_select <= RST_ZERO;
      irq_event_polarity    <= RST_ZERO;
      irq_mask_reg          <= RST_ZERO;
    end else if (wr_in) begin
      unique case (addr_in)
        OFS_DIRECTION:  pin_direction_reg     <= wbyte;
        OFS_SENSE:      irq_sense_select      <= wbyte;
        OFS_BOTH_EDGES: irq_both_edges_select <= wbyte;
        OFS_EVENT:      irq_event_polarity    <= wbyte;
        OFS_MASK:       irq_mask_reg          <= wbyte;
        default: ;
      endcase
    end
  end

  // pad configuration; drive selects and pulls are exclusive
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      drive_low_select     <= RST_DRIVE_LOW;
      drive_mid_select     <= RST_ZERO;
      drive_high_select    <= RST_ZERO;
      open_drain_select    <= RST_ZERO;
      slew_select          <= RST_ZERO;
      pull_up_select       <= debug_pins;
      pull_down_select     <= RST_ZERO;
      digital_input_enable <= debug_pins;
    end else if (wr_in) begin
      unique case (addr_in)
        OFS_DRIVE_LOW: begin
          drive_low_select  <= drive_low_select | wbyte;
          drive_mid_select  <= drive_mid_select & ~wbyte;
          drive_high_select <= drive_high_select & ~wbyte;
          // lowering a pin's drive drops its slew setting too
          slew_select       <= slew_select & ~wbyte;
        end
        OFS_DRIVE_MID: begin
          drive_low_select  <= drive_low_select & ~wbyte;
          drive_mid_select  <= drive_mid_select | wbyte;
          drive_high_select <= drive_high_select & ~wbyte;
          slew_select       <= slew_select & ~wbyte;
        end
        OFS_DRIVE_HIGH: begin
          drive_low_select  <= drive_low_select & ~wbyte;
          drive_mid_select  <= drive_mid_select & ~wbyte;
          drive_high_select <= drive_high_select | wbyte;
        end
        OFS_OPEN_DRAIN: open_drain_select <= wbyte;
        // slew only sticks on 8 mA pins, so the output needs no gate
        OFS_SLEW: slew_select <= wbyte & drive_high_select;
        OFS_PULL_UP: begin
          pull_up_select   <= wbyte;
          pull_down_select <= pull_down_select & ~wbyte;
        end
        OFS_PULL_DOWN: begin
          pull_down_select <= wbyte;
          pull_up_select   <= pull_up_select & ~wbyte;
        end
        OFS_DIGITAL_EN: digital_input_enable <= wbyte;
        default: ;
      endcase
    end
  end

  // protected bits need unlock and permit; others always writable
  // ordinary pins ignore the permit and lock entirely
  assign alt_writable = ~debug_pins |
                        (commit_permit_reg & {8{~commit_lock_reg}});

  // alternate select, lock and commit permit
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      alt_function_select <= debug_pins;
      commit_lock_reg     <= RST_LOCKED;
      commit_permit_reg   <= ~debug_pins;
    end else if (wr_in) begin
      if (addr_in == OFS_ALT_SELECT) begin
        alt_function_select <= merge(alt_function_select, wbyte,
                                     alt_writable);
      end
      if (addr_in == OFS_LOCK) begin
        commit_lock_reg <= (wdata_in != UNLOCK_KEY);
      end
      // permit bits of ordinary pins read as one, fixed
      if (addr_in == OFS_COMMIT && !commit_lock_reg) begin
        commit_permit_reg <= merge(commit_permit_reg, wbyte,
                                   debug_pins);
      end
    end
  end

  // trigger selection: sense 1 level, else edges
  // changing these selects while unmasked may raise a false status
  always_comb begin
    level_hit = irq_sense_select &
                ~(pad_sync ^ irq_event_polarity);
    edge_hit  = ~irq_sense_select &
                (irq_both_edges_select & (pad_sync ^ pad_prev) |
                 ~irq_both_edges_select &
                 (irq_event_polarity & pad_sync & ~pad_prev |
                  ~irq_event_polarity & ~pad_sync & pad_prev));
  end

  // clear strobe, only during a write to the clear word
  assign clear_bits = (wr_in && addr_in == OFS_CLEAR) ? wbyte : RST_ZERO;

  // edge latch: a new edge beats a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      edge_latch <= RST_ZERO;
    end else begin
      edge_latch <= (edge_latch & ~clear_bits) | edge_hit;
    end
  end

  // level conditions follow the pin; the source must hold them
  assign raw_irq_status    = (edge_latch & ~irq_sense_select) |
                             level_hit;
  assign masked_irq_status = raw_irq_status & irq_mask_reg;

  // port interrupt, registered
  // costs a cycle of latency but keeps the line glitch-free
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |masked_irq_status;
    end
  end

  // pad mux: peripheral or software; open drain only pulls low
  // the mux is registered below so pads never see decode glitches
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (alt_function_select[i]) begin
        next_pad_out[i] = alt_out_in[i];
        next_pad_oe[i]  = alt_oe_in[i];
      end else begin
        next_pad_out[i] = pin_value_reg[i];
        next_pad_oe[i]  = pin_direction_reg[i];
      end
      if (open_drain_select[i]) begin
        next_pad_oe[i]  = next_pad_oe[i] & ~next_pad_out[i];
        next_pad_out[i] = 1'b0;
      end
    end
    next_pad_oe = next_pad_oe & present_pins;
  end

  // registered pad outputs; one cycle behind the registers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pad_out    <= RST_ZERO;
      pad_oe_out <= RST_ZERO;
      alt_in_out <= RST_ZERO;
    end else begin
      pad_out    <= next_pad_out;
      pad_oe_out <= next_pad_oe;
      alt_in_out <= pin_in;
    end
  end

  // pad configuration outputs are the registers themselves
  assign drive_low_out  = drive_low_select;
  assign drive_mid_out  = drive_mid_select;
  assign drive_high_out = drive_high_select;
  assign slew_out       = slew_select;
  assign pull_up_out    = pull_up_select;
  assign pull_down_out  = pull_down_select;
  assign dig_en_out     = digital_input_enable;

  // read mux; input pins return the captured pad level
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (data_hit) begin
      next_rdata[7:0] = ((pin_value_reg & pin_direction_reg) |
                         (pin_in & ~pin_direction_reg)) &
                        data_mask;
    end else if (addr_in[1:0] == 2'b00 && addr_in >= OFS_CELL_ID0) begin
      // four cell words at the very top of the map
      next_rdata[7:0] = CELL_ID[addr_in[3:2]];
    end else if (addr_in[1:0] == 2'b00 && addr_in >= OFS_PERIPH_ID0 &&
                 addr_in < OFS_CELL_ID0) begin
      // eight peripheral words just below the cell words
      next_rdata[7:0] = PERIPH_ID[id_off[4:2]];
    end else begin
      unique case (addr_in)
        OFS_DIRECTION:   next_rdata[7:0] = pin_direction_reg;
        OFS_SENSE:       next_rdata[7:0] = irq_sense_select;
        OFS_BOTH_EDGES:  next_rdata[7:0] = irq_both_edges_select;
        OFS_EVENT:       next_rdata[7:0] = irq_event_polarity;
        OFS_MASK:        next_rdata[7:0] = irq_mask_reg;
        OFS_RAW_STATUS:  next_rdata[7:0] = raw_irq_status;
        OFS_MASK_STATUS: next_rdata[7:0] = masked_irq_status;
        OFS_ALT_SELECT:  next_rdata[7:0] = alt_function_select;
        OFS_DRIVE_LOW:   next_rdata[7:0] = drive_low_select;
        OFS_DRIVE_MID:   next_rdata[7:0] = drive_mid_select;
        OFS_DRIVE_HIGH:  next_rdata[7:0] = drive_high_select;
        OFS_OPEN_DRAIN:  next_rdata[7:0] = open_drain_select;
        OFS_PULL_UP:     next_rdata[7:0] = pull_up_select;
        OFS_PULL_DOWN:   next_rdata[7:0] = pull_down_select;
        OFS_SLEW:        next_rdata[7:0] = slew_select;
        OFS_DIGITAL_EN:  next_rdata[7:0] = digital_input_enable;
        OFS_LOCK:        next_rdata[0]   = commit_lock_reg;
        OFS_COMMIT:      next_rdata[7:0] = commit_permit_reg;
        default:         next_rdata      = 32'h0000_0000;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= rd_in ? next_rdata : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

/* rtl/gpio_port_pkg.sv */
/*
  constants for the eight-bit general-purpose port: register offsets,
  reset values, lock key and identification bytes.
  assumes a 12-bit byte address and 32-bit data on the register port.
*/
`default_nettype none
package gpio_port_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PINS   = 8;

  // register byte offsets
  localparam logic [11:0] OFS_DIRECTION   = 12'h400;
  localparam logic [11:0] OFS_SENSE       = 12'h404;
  localparam logic [11:0] OFS_BOTH_EDGES  = 12'h408;
  localparam logic [11:0] OFS_EVENT       = 12'h40c;
  localparam logic [11:0] OFS_MASK        = 12'h410;
  localparam logic [11:0] OFS_RAW_STATUS  = 12'h414;
  localparam logic [11:0] OFS_MASK_STATUS = 12'h418;
  localparam logic [11:0] OFS_CLEAR       = 12'h41c;
  localparam logic [11:0] OFS_ALT_SELECT  = 12'h420;
  localparam logic [11:0] OFS_DRIVE_LOW   = 12'h500;
  localparam logic [11:0] OFS_DRIVE_MID   = 12'h504;
  localparam logic [11:0] OFS_DRIVE_HIGH  = 12'h508;
  localparam logic [11:0] OFS_OPEN_DRAIN  = 12'h50c;
  localparam logic [11:0] OFS_PULL_UP     = 12'h510;
  localparam logic [11:0] OFS_PULL_DOWN   = 12'h514;
  localparam logic [11:0] OFS_SLEW        = 12'h518;
  localparam logic [11:0] OFS_DIGITAL_EN  = 12'h51c;
  localparam logic [11:0] OFS_LOCK        = 12'h520;
  localparam logic [11:0] OFS_COMMIT      = 12'h524;
  localparam logic [11:0] OFS_PERIPH_ID0  = 12'hfd0;
  localparam logic [11:0] OFS_CELL_ID0    = 12'hff0;

  // data window: address bits [11:10] zero, mask in bits [9:2]
  localparam int unsigned DATA_MASK_LSB = 2;
  localparam int unsigned DATA_MASK_MSB = 9;

  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_DRIVE_LOW  = 8'hff;
  localparam logic [7:0] RST_DEBUG_PINS = 8'h0f;
  localparam logic [7:0] RST_PRESENT    = 8'hff;
  localparam logic       RST_LOCKED     = 1'b1;

  // unlock key, value arbitrary
  localparam logic [31:0] UNLOCK_KEY = 32'h5a5a_c3c3;

  // identification bytes, values arbitrary
  localparam logic [7:0] PERIPH_ID [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h11, 8'h22, 8'h33, 8'h44};
  localparam logic [7:0] CELL_ID [4]   = '{8'h0a, 8'h0b, 8'h0c, 8'h0d};

endpackage
`default_nettype wire

/* verification/gpio_port_block_checker.sv */
/*
  concurrent checks on the pins of the eight-bit port block.
  assumes one clock, synchronous active-low reset, registered outputs.
*/
`default_nettype none
module gpio_port_block_checker
  import gpio_port_pkg::*;
#(
  parameter logic [7:0] debug_pins = gpio_port_pkg::RST_DEBUG_PINS
) (
  input wire logic                              mclk_in,        // clock
  input wire logic                              rstn_in,        // reset
  input wire logic                              wr_in,          // wr strobe
  input wire logic                              rd_in,          // rd strobe
  input wire logic [gpio_port_pkg::DATA_W-1:0]  rdata_out,      // rd data
  input wire logic [7:0]                        pad_in,         // pad level
  input wire logic [7:0]                        pad_oe_out,     // pad enable
  input wire logic [7:0]                        alt_in_out,     // to periph
  input wire logic [7:0]                        drive_low_out,  // 2 mA
  input wire logic [7:0]                        drive_mid_out,  // 4 mA
  input wire logic [7:0]                        drive_high_out, // 8 mA
  input wire logic [7:0]                        slew_out,       // slew
  input wire logic [7:0]                        pull_up_out,    // pull-up
  input wire logic [7:0]                        pull_down_out,  // pull-down
  input wire logic [7:0]                        dig_en_out,     // input en
  input wire logic                              irq_out         // interrupt
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  logic [3:0] quiet;  // edges since a write or pad move
  logic [3:0] settle; // edges since reset release

  // saturating counters; pads held during reset may still be in flight
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      quiet  <= 4'hf;
      settle <= 4'h0;
    end else begin
      if (wr_in || $changed(pad_in)) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
      if (settle != 4'hf) settle <= settle + 4'h1;
    end
  end

  // a peripheral input change needs a pad move two to four edges back or a recent digital enable change
  sequence s_sync_cause;
    $past(pad_in, 2) != $past(pad_in, 3) || $past(pad_in, 3) != $past(pad_in, 4)
      || $past(pad_in, 4) != $past(pad_in, 5) || $changed(dig_en_out)
      || $past(dig_en_out) != $past(dig_en_out, 2);
  endsequence

  a_reset_defaults: assert property (disable iff (1'b0) !rstn_in |=>
    pad_oe_out == 8'h00 && pull_up_out == debug_pins && irq_out == 1'b0
    && dig_en_out == debug_pins && drive_low_out == 8'hff
    && pull_down_out == 8'h00) else $error("reset defaults wrong");
  a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data outside read slot");
  a_pull_exclusive: assert property ((pull_up_out & pull_down_out) == 8'h00)
    else $error("pull-up and pull-down both on");
  a_drive_exclusive: assert property (((drive_low_out & drive_mid_out)
    | (drive_low_out & drive_high_out) | (drive_mid_out & drive_high_out))
    == 8'h00) else $error("two drive strengths on one pin");
  a_slew_high_only: assert property ((slew_out & ~drive_high_out) == 8'h00)
    else $error("slew without 8 mA drive");
  a_alt_in_gated: assert property
    ((alt_in_out & ~$past(dig_en_out) & ~dig_en_out) == 8'h00)
    else $error("input passed with digital enable off");
  a_sync_delay: assert property ($changed(alt_in_out) && settle > 4'h5
    |-> s_sync_cause) else $error("peripheral input moved without cause");
  a_irq_has_cause: assert property ($rose(irq_out) |-> quiet <= 4'h6)
    else $error("interrupt rose without cause");
endmodule

bind gpio_port_block gpio_port_block_checker #(.debug_pins(debug_pins))
  u_checker (.mclk_in, .rstn_in, .wr_in, .rd_in, .rdata_out, .pad_in,
  .pad_oe_out, .alt_in_out, .drive_low_out, .drive_mid_out,
  .drive_high_out, .slew_out, .pull_up_out, .pull_down_out, .dig_en_out,
  .irq_out);
`default_nettype wire

/* verification/gpio_pad_model.sv */
/*
  pad ring model: resolves each pad from device drive, outside source
  and pulls. assumes the outside source is set by the bench.
*/
`default_nettype none
module gpio_pad_model (
  input  wire logic       mclk_in,       // clock
  input  wire logic [7:0] pad_out,       // device drive value
  input  wire logic [7:0] pad_oe_out,    // device drives pad
  input  wire logic [7:0] pull_up_out,   // pull-up on
  input  wire logic [7:0] pull_down_out, // pull-down on
  input  wire logic [7:0] ext_level,     // outside source level
  input  wire logic [7:0] ext_drive,     // outside source active
  output logic      [7:0] pad_in         // resolved level
);
  logic [7:0] drift = 8'h55; // floating pads wander

  // an undriven, unpulled pad must not look steady
  always_ff @(posedge mclk_in) begin
    drift <= ~drift;
  end

  // device drive wins, then outside source, then pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe_out[i]) pad_in[i] = pad_out[i];
      else if (ext_drive[i]) pad_in[i] = ext_level[i];
      else if (pull_up_out[i]) pad_in[i] = 1'b1;
      else if (pull_down_out[i]) pad_in[i] = 1'b0;
      else pad_in[i] = drift[i];
    end
  end
endmodule
`default_nettype wire

/* verification/gpio_port_block_tb_top.sv */
/*
  self-checking bench for the port block with a pad model.
  assumes the package offsets and the register timing of the block.
*/
`default_nettype none
module gpio_port_block_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_port_pkg::*;
  localparam logic [7:0]  PRESENT = 8'h7f; // top pin left unbonded
  localparam logic [31:0] RM      = {24'h0, PRESENT};
  logic        mclk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic [7:0]  alt_out_in = 8'h00, alt_oe_in = 8'h00;
  logic [7:0]  ext_level = 8'h00, ext_drive = 8'h00;
  logic [7:0]  pad_in, pad_out, pad_oe_out, alt_in_out, drive_low_out;
  logic [7:0]  drive_mid_out, drive_high_out, slew_out, pull_up_out;
  logic [7:0]  pull_down_out, dig_en_out;
  logic        irq_out;
  int          n_errors = 0, checks = 0;
  // sense, both, event, start level, end level, expected status
  logic [47:0] modes [8] = '{48'h00_00_ff_00_ff_ff, 48'h00_00_ff_ff_00_00,
    48'h00_00_00_ff_00_ff, 48'h00_ff_00_00_ff_ff, 48'h00_ff_ff_ff_00_ff,
    48'hff_00_ff_00_ff_ff, 48'hff_00_00_ff_00_ff, 48'hff_00_00_00_ff_00};

  always #10 mclk_in = ~mclk_in;

  gpio_port_block #(.debug_pins(RST_DEBUG_PINS), .present_pins(PRESENT)) DUT (
    .mclk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .pad_in, .pad_out, .pad_oe_out, .alt_out_in, .alt_oe_in, .alt_in_out,
    .drive_low_out, .drive_mid_out, .drive_high_out, .slew_out,
    .pull_up_out, .pull_down_out, .dig_en_out, .irq_out);
  gpio_pad_model pads (.mclk_in, .pad_out, .pad_oe_out, .pull_up_out,
    .pull_down_out, .ext_level, .ext_drive, .pad_in);

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pchk(input string what, input logic [7:0] exp, got);
    chk(what, {24'h0, exp}, {24'h0, got});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  // unbonded bits may read anything, so they are masked off
  task automatic rchk(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    chk(what, exp & RM, rdata_out & RM);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  task automatic t_reset;
    pchk("pad_oe", 8'h00, pad_oe_out);
    pchk("pull_down", 8'h00, pull_down_out);
    pchk("pull_up", RST_DEBUG_PINS, pull_up_out);
    pchk("dig_en", RST_DEBUG_PINS, dig_en_out);
    rchk("alt_sel", OFS_ALT_SELECT, {24'h0, RST_DEBUG_PINS});
    rchk("permit", OFS_COMMIT, {24'h0, ~RST_DEBUG_PINS});
    rchk("lock", OFS_LOCK, 32'h1);
    for (int i = 0; i < 8; i++)
      rchk("periph_id", OFS_PERIPH_ID0 + 12'(4 * i), {24'h0, PERIPH_ID[i]});
    for (int i = 0; i < 4; i++)
      rchk("cell_id", OFS_CELL_ID0 + 12'(4 * i), {24'h0, CELL_ID[i]});
    wr(12'h600, 32'hff);
    rchk("unmapped", 12'h600, 32'h0);
  endtask

  task automatic t_commit;
    wr(OFS_ALT_SELECT, 32'h0);
    rchk("alt_locked", OFS_ALT_SELECT, 32'h0f);
    wr(OFS_LOCK, UNLOCK_KEY);
    wr(OFS_ALT_SELECT, 32'h0);
    rchk("alt_no_permit", OFS_ALT_SELECT, 32'h0f);
    wr(OFS_COMMIT, 32'h0f);
    wr(OFS_ALT_SELECT, 32'h0);
    rchk("alt_committed", OFS_ALT_SELECT, 32'h0);
    wr(OFS_LOCK, 32'h0);
    rchk("relocked", OFS_LOCK, 32'h1);
  endtask

  task automatic t_data;
    wr(OFS_DIGITAL_EN, 32'hff);
    wr(OFS_DIRECTION, 32'hff);
    wr(12'h3fc, 32'h00);
    wr(12'h098, 32'heb);
    rchk("data_masked", 12'h0c4, 32'h20);
    rchk("data_all", 12'h3fc, 32'h22);
    wait_n(2);
    pchk("pad_out", 8'h22, pad_out & PRESENT);
    pchk("pad_oe", PRESENT, pad_oe_out);
    wr(OFS_DIRECTION, 32'h00);
    ext_drive <= 8'hff;
    ext_level <= 8'h5a;
    wait_n(5);
    rchk("data_in", 12'h3fc, 32'h5a);
    pchk("alt_in", 8'h5a, alt_in_out & PRESENT);
  endtask

  task automatic t_irq_mode(input logic [47:0] m);
    wr(OFS_MASK, 32'h0);
    ext_level <= m[23:16];
    wr(OFS_SENSE, {24'h0, m[47:40]});
    wr(OFS_BOTH_EDGES, {24'h0, m[39:32]});
    wr(OFS_EVENT, {24'h0, m[31:24]});
    wait_n(6);
    wr(OFS_CLEAR, 32'hff);
    ext_level <= m[15:8];
    wait_n(6);
    rchk("raw", OFS_RAW_STATUS, {24'h0, m[7:0]});
    rchk("masked_off", OFS_MASK_STATUS, 32'h0);
    pchk("irq_off", 8'h00, {7'h0, irq_out});
    wr(OFS_MASK, 32'h01);
    wait_n(2);
    rchk("masked_on", OFS_MASK_STATUS, {31'h0, m[0]});
    pchk("irq_on", {7'h0, m[0]}, {7'h0, irq_out});
    wr(OFS_CLEAR, 32'h00);
    rchk("clear_zero", OFS_RAW_STATUS, {24'h0, m[7:0]});
    wr(OFS_CLEAR, 32'hff);
    rchk("cleared", OFS_RAW_STATUS, {24'h0, m[7:0] & m[47:40]});
  endtask

  task automatic t_alt_pad;
    wr(OFS_ALT_SELECT, 32'h10);
    ext_drive <= 8'hef;
    alt_out_in <= 8'h10;
    alt_oe_in <= 8'h10;
    wait_n(3);
    pchk("alt_oe", 8'h10, pad_oe_out);
    pchk("alt_val", 8'h10, pad_out & 8'h10);
    alt_out_in <= 8'h00;
    wait_n(3);
    pchk("alt_low", 8'h00, pad_out & 8'h10);
    wr(OFS_DRIVE_HIGH, 32'h01);
    wr(OFS_SLEW, 32'h03);
    wr(OFS_PULL_DOWN, 32'h01);
    wait_n(1);
    pchk("drive_low", 8'hfe & PRESENT, drive_low_out & PRESENT);
    pchk("slew", 8'h01, slew_out);
    pchk("pull_up", 8'h0e, pull_up_out);
  endtask

  task automatic t_mid_reset;
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    wait_n(1);
    pchk("pull_up", RST_DEBUG_PINS, pull_up_out);
    pchk("drive_low", 8'hff, drive_low_out);
    rchk("alt_sel", OFS_ALT_SELECT, {24'h0, RST_DEBUG_PINS});
    rchk("direction", OFS_DIRECTION, 32'h0);
  endtask

  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    wait_n(1);
    t_reset;
    t_commit;
    t_data;
    for (int i = 0; i < 8; i++) t_irq_mode(modes[i]);
    t_alt_pad;
    t_mid_reset;
    end_of_test;
  end

  // the run needs about 450 cycles; this allows over thirty times that
  initial begin
    #300us;
    n_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
